/* File: hw/bdv_defs.svh */
// constants for the bus debug visibility block
`ifndef BDV_DEFS_SVH
`define BDV_DEFS_SVH
`define BDV_ADDR_W      16
`define BDV_DATA_W      8
`define BDV_DATA_RST    8'h00
// register-block window of the replaced parallel ports and handshake
`define BDV_PORT_LO     6'h02
`define BDV_PORT_HI     6'h07
`define BDV_REG_OFS_W   6
// mode pin pair values (B,A)
`define BDV_PINS_NSC    2'h2
`define BDV_PINS_NEXP   2'h3
`define BDV_PINS_SBOOT  2'h0
`define BDV_PINS_STEST  2'h1
`define BDV_ECHO_RST    1'h0
`endif

/* File: hw/bdv_pkg.sv */
// types for the bus debug visibility block
package bdv_pkg;
  typedef enum logic [1:0] {
    BDV_NORM_SINGLE,
    BDV_NORM_EXP,
    BDV_SPEC_BOOT,
    BDV_SPEC_TEST
  } bdv_mode_t;
endpackage

/* File: hw/bdv_top.sv */
// bus debug visibility: boundary marker, internal read echo, expansion bus treatment
`timescale 1ns/1ps
`include "bdv_defs.svh"

// Functional notes
// [R1] marker pin pulled low on first bus cycle of each instruction, released otherwise
// [R2] echo bit 1: internal read data driven onto external data bus
// [R3] echo bit 0: data bus undriven on internal-address reads
// [R4] reset into a normal mode starts the echo bit at 0
// [R5] legacy variant: writing 1 in normal modes is ignored
// [R6] special modes start echo at 1; clearing it locks it
// [R7] newer variant: writing 1 accepted in any mode unless cleared since reset
// [R8] after a write of 0 echo stays off until next reset
// [R9] echo drives the bus on internal reads despite read direction
// [R10] external logic must avoid contention while echo is on
// [R11] normal expanded: bus undriven during nonvolatile memory reads
// [R12] expanded modes: port and handshake registers accessed externally
// [R13] handshake interrupts share the external interrupt request vector
// [R14] expanded modes hand the port pins to the expansion bus
// [R15] mode latched from pin pair at reset: 10,11,00,01 as documented
// [R16] after reset pin A becomes open-drain marker, no longer sampled
// [R17] sticky write lock cleared by reset; parameter picks write permission variant
module bdv_top #(
  parameter bit NEWER_VARIANT = 1'b0
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_mode_pin_a,
  input  wire logic                     i_mode_pin_b,
  input  wire logic                     i_cyc,
  input  wire logic                     i_instr_first,
  input  wire logic                     i_rd,
  input  wire logic [`BDV_ADDR_W-1:0]   i_addr,
  input  wire logic                     i_addr_internal,
  input  wire logic                     i_reg_block_hit,
  input  wire logic                     i_nvm_hit,
  input  wire logic [`BDV_DATA_W-1:0]   i_int_rd_data,
  input  wire logic                     i_echo_wr,
  input  wire logic                     i_echo_wdata,
  input  wire logic                     i_ext_irq,
  input  wire logic                     i_hs_irq,
  output logic                          o_marker_out,
  output logic                          o_marker_oe,
  output logic [`BDV_DATA_W-1:0]        o_data_out,
  output logic                          o_data_oe,
  output logic                          o_internal_read_echo,
  output logic [1:0]                    o_mode,
  output logic                          o_ext_access,
  output logic                          o_irq_req,
  output logic                          o_port_bus_sel
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic is_special(input bdv_pkg::bdv_mode_t m);
    is_special = (m == bdv_pkg::BDV_SPEC_BOOT) || (m == bdv_pkg::BDV_SPEC_TEST);
  endfunction

  function automatic logic is_expanded(input bdv_pkg::bdv_mode_t m);
    is_expanded = (m == bdv_pkg::BDV_NORM_EXP) || (m == bdv_pkg::BDV_SPEC_TEST);
  endfunction

  function automatic bdv_pkg::bdv_mode_t pins_to_mode(input logic [1:0] p);
    unique case (p)
      `BDV_PINS_NSC:   pins_to_mode = bdv_pkg::BDV_NORM_SINGLE;
      `BDV_PINS_NEXP:  pins_to_mode = bdv_pkg::BDV_NORM_EXP;
      `BDV_PINS_SBOOT: pins_to_mode = bdv_pkg::BDV_SPEC_BOOT;
      `BDV_PINS_STEST: pins_to_mode = bdv_pkg::BDV_SPEC_TEST;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // mode pin synchroniser: no reset, so it keeps sampling while reset is held

  logic [1:0]          pin_s1_r;
  logic [1:0]          pin_s2_r;
  logic                started_r;
  bdv_pkg::bdv_mode_t  mode_r;
  logic                echo_r;
  logic                lock_r;
  logic                port_hit;
  logic                echo_drive;

  always_ff @(posedge i_clk) begin
    pin_s1_r <= {i_mode_pin_b, i_mode_pin_a};
    pin_s2_r <= pin_s1_r;
  end

  // first edge after release captures the mode; later pin A is an output only
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      started_r <= 1'b0;
      mode_r    <= bdv_pkg::BDV_NORM_SINGLE;
    end else if (!started_r) begin
      started_r <= 1'b1;
      mode_r    <= pins_to_mode(pin_s2_r); // [R15] [R16]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // echo bit and its sticky write lock

  // lock only ever sets; only reset can reopen the echo bit
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lock_r <= 1'b0;
    end else if (started_r && i_echo_wr && !i_echo_wdata) begin
      lock_r <= 1'b1; // [R17] [R8]
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      echo_r <= `BDV_ECHO_RST;
    end else if (!started_r) begin
      echo_r <= is_special(pins_to_mode(pin_s2_r)); // [R4] [R6]
    end else if (i_echo_wr) begin
      if (!i_echo_wdata) begin
        echo_r <= 1'b0; // [R8]
      end else if (!lock_r && (NEWER_VARIANT || is_special(mode_r))) begin
        echo_r <= 1'b1; // [R7] [R5]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all registered; data, marker and external access follow the cycle strobe by one cycle

  assign port_hit = i_reg_block_hit &&
                    (i_addr[`BDV_REG_OFS_W-1:0] >= `BDV_PORT_LO) &&
                    (i_addr[`BDV_REG_OFS_W-1:0] <= `BDV_PORT_HI);

  // echo drives even though the cycle is a read; external decode must keep off [R10]
  // port window is only external in expanded modes; single-chip port reads stay echoed [R12]
  assign echo_drive = started_r && i_cyc && i_rd && i_addr_internal && echo_r &&
                      !(is_expanded(mode_r) && port_hit) &&
                      !((mode_r == bdv_pkg::BDV_NORM_EXP) && i_nvm_hit); // [R2] [R3] [R9] [R11]

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_data_oe  <= 1'b0;
      o_data_out <= `BDV_DATA_RST;
    end else begin
      o_data_oe  <= echo_drive; // [R2] [R3]
      o_data_out <= echo_drive ? i_int_rd_data : `BDV_DATA_RST;
    end
  end

  // open drain: output value is always low, only the enable moves
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_marker_out <= 1'b0;
      o_marker_oe  <= 1'b0;
    end else begin
      o_marker_out <= 1'b0;
      o_marker_oe  <= started_r && i_cyc && i_instr_first; // [R1] [R16]
    end
  end

  // ports replaced by the expansion bus become external addresses
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ext_access <= 1'b0;
    end else begin
      o_ext_access <= started_r && i_cyc &&
                      (!i_addr_internal || (is_expanded(mode_r) && port_hit)); // [R12]
    end
  end

  // a replacement chip on the external request line is then serviced identically
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq_req <= 1'b0;
    end else begin
      o_irq_req <= i_ext_irq || i_hs_irq; // [R13]
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_port_bus_sel       <= 1'b0;
      o_mode               <= 2'h0;
      o_internal_read_echo <= 1'b0;
    end else begin
      o_port_bus_sel       <= started_r && is_expanded(mode_r); // [R14]
      o_mode               <= mode_r;
      o_internal_read_echo <= echo_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_marker_first_cycle: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R1]
    started_r && i_cyc |=> (o_marker_oe == $past(i_instr_first)))
    else $error("marker does not follow instruction start");

  a_echo_drives_data: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R2]
    echo_drive |=> o_data_oe && (o_data_out == $past(i_int_rd_data)))
    else $error("echo read not driven");

  a_echo_off_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R3]
    !echo_r |=> !o_data_oe)
    else $error("bus driven with echo off");

  a_normal_reset_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R4]
    $rose(started_r) && !is_special(mode_r) |-> !echo_r)
    else $error("echo not cleared in normal mode");

  a_legacy_refuse: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R5]
    !NEWER_VARIANT && started_r && !is_special(mode_r) && !echo_r |=> !echo_r)
    else $error("legacy normal mode accepted echo set");

  a_special_start_one: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R6]
    $rose(started_r) && is_special(mode_r) |-> echo_r)
    else $error("echo not set in special mode");

  a_newer_accept: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R7]
    NEWER_VARIANT && started_r && i_echo_wr && i_echo_wdata && !lock_r |=> echo_r)
    else $error("newer variant refused echo set");

  a_lock_holds: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R8]
    started_r && i_echo_wr && !i_echo_wdata |=> !echo_r ##1 (!echo_r && lock_r))
    else $error("echo reopened after clear");

  a_nvm_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R11]
    (mode_r == bdv_pkg::BDV_NORM_EXP) && i_nvm_hit |=> !o_data_oe)
    else $error("bus driven on nonvolatile read");

  a_port_external: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R12]
    started_r && i_cyc && is_expanded(mode_r) && port_hit |=> o_ext_access && !o_data_oe)
    else $error("port access not external");

  a_irq_shared: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R13]
    i_hs_irq |=> o_irq_req)
    else $error("handshake interrupt lost");

  a_mode_stable: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R15]
    started_r && $past(started_r) |-> $stable(mode_r))
    else $error("mode changed after reset");

  c_echo_read: cover property (@(posedge i_clk) disable iff (!i_rst_n) echo_drive ##1 o_data_oe);
  c_echo_clear: cover property (@(posedge i_clk) disable iff (!i_rst_n) echo_r ##1 !echo_r);
  c_marker: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_marker_oe ##1 !o_marker_oe);
  c_port_ext: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_ext_access && o_port_bus_sel);

endmodule

/* File: verif/bdv_ext_model.sv */
// far side model: external bus device plus strapped open-drain marker pin
`timescale 1ns/1ps
module bdv_ext_model (
  input  wire logic       i_clk,
  input  wire logic       i_ext_rd,
  input  wire logic       i_dev_oe,
  input  wire logic [7:0] i_dev_data,
  input  wire logic [7:0] i_ext_data,
  input  wire logic       i_mk_oe,
  input  wire logic       i_strap,
  output logic [7:0]      o_bus,
  output logic            o_pin_a
);
  logic [7:0] float_r  = 8'h3C;
  logic       ext_rd_r = 1'b0;
  // a released bus must not hold a steady value, else a missing drive could pass
  always @(posedge i_clk) begin
    float_r <= ~float_r + 8'h01;
  end
  // data phase trails the request by one edge, the same slot as the echo drive
  always @(posedge i_clk) begin
    ext_rd_r <= i_ext_rd;
  end
  // device answers only on decoded external reads; a clash shows as unknown
  assign o_bus = (i_dev_oe && ext_rd_r) ? 8'hXX :
                 i_dev_oe ? i_dev_data : ext_rd_r ? i_ext_data : float_r;
  // open-drain marker: strap resistor sets the level unless pulled low
  assign o_pin_a = i_mk_oe ? 1'b0 : i_strap;
endmodule

/* File: verif/bdv_top_tb.sv */
// self-checking testbench for the bus debug visibility block
`timescale 1ns/1ps
module bdv_top_tb;
  logic        clk, rst_n, pa, pb, cyc, first, rd, intl, regh, nvm, ewr, ewd, xirq, hirq;
  logic [15:0] addr;
  logic [7:0]  rdat;
  wire logic   m_out, m_oe, d_oe, echo, xacc, irq, psel, pin_a;
  wire logic [7:0] d_out, bus;
  wire logic [1:0] mode;
  wire logic   echo_n, d_oe_n;
  wire logic [7:0] d_out_n;
  int          bad_count, checks_done, cycles;
  //////////////////////////////////////////////////////////////////////////////
  bdv_top #(.NEWER_VARIANT(1'b0)) u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_mode_pin_a(pin_a),
    .i_mode_pin_b(pb), .i_cyc(cyc), .i_instr_first(first), .i_rd(rd), .i_addr(addr),
    .i_addr_internal(intl), .i_reg_block_hit(regh), .i_nvm_hit(nvm), .i_int_rd_data(rdat),
    .i_echo_wr(ewr), .i_echo_wdata(ewd), .i_ext_irq(xirq), .i_hs_irq(hirq),
    .o_marker_out(m_out), .o_marker_oe(m_oe), .o_data_out(d_out), .o_data_oe(d_oe),
    .o_internal_read_echo(echo), .o_mode(mode), .o_ext_access(xacc), .o_irq_req(irq),
    .o_port_bus_sel(psel));
  // second copy with the newer write permission, fed the same stimulus
  bdv_top #(.NEWER_VARIANT(1'b1)) u_dut_new (.i_clk(clk), .i_rst_n(rst_n), .i_mode_pin_a(pin_a),
    .i_mode_pin_b(pb), .i_cyc(cyc), .i_instr_first(first), .i_rd(rd), .i_addr(addr),
    .i_addr_internal(intl), .i_reg_block_hit(regh), .i_nvm_hit(nvm), .i_int_rd_data(rdat),
    .i_echo_wr(ewr), .i_echo_wdata(ewd), .i_ext_irq(xirq), .i_hs_irq(hirq),
    .o_marker_out(), .o_marker_oe(), .o_data_out(d_out_n), .o_data_oe(d_oe_n),
    .o_internal_read_echo(echo_n), .o_mode(), .o_ext_access(), .o_irq_req(),
    .o_port_bus_sel());
  bdv_ext_model u_ext (.i_clk(clk), .i_ext_rd(cyc && rd && !intl), .i_dev_oe(d_oe),
    .i_dev_data(d_out), .i_ext_data(8'hC3), .i_mk_oe(m_oe), .i_strap(pa), .o_bus(bus),
    .o_pin_a(pin_a));
  //////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // pins stay put through reset and two edges after release
  task automatic do_reset(input logic b, input logic a);
    rst_n = 1'b0;
    pb = b;
    pa = a;
    cyc = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask
  task automatic mode_case(input logic b, a, input logic [1:0] em, input logic ee, ep);
    do_reset(b, a);
    chk(mode, em);
    chk(echo, ee);
    chk(psel, ep);
  endtask
  // cyc is left high so calls run back to back; answer lands one edge later
  task automatic bus_cyc(input logic f, r, i, h, n, input logic [15:0] a, input logic eoe, ex);
    first = f;
    rd = r;
    intl = i;
    regh = h;
    nvm = n;
    addr = a;
    rdat = a[7:0] ^ 8'hA5;
    cyc = 1'b1;
    @(negedge clk);
    chk(m_oe, f);
    chk(d_oe, eoe);
    chk(d_out, eoe ? (a[7:0] ^ 8'hA5) : 8'h00);
    if (eoe) chk(bus, a[7:0] ^ 8'hA5);
    chk(xacc, ex);
    chk(m_out, 1'b0);
    if (r && !i) chk(bus, 8'hC3);
  endtask
  task automatic wr_echo(input logic v, input logic exp, input logic exp_n);
    ewr = 1'b1;
    ewd = v;
    @(negedge clk);
    ewr = 1'b0;
    @(negedge clk);
    chk(echo, exp);
    chk(echo_n, exp_n);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // hang guard: the whole sequence needs about 52 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles > 3000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    {rst_n, pa, pb, cyc, first, rd, intl, regh, nvm, ewr, ewd, xirq, hirq} = 13'h0000;
    addr = 16'h0000;
    rdat = 8'h00;
    mode_case(1'b1, 1'b0, bdv_pkg::BDV_NORM_SINGLE, 1'b0, 1'b0);
    mode_case(1'b1, 1'b1, bdv_pkg::BDV_NORM_EXP, 1'b0, 1'b1);
    mode_case(1'b0, 1'b0, bdv_pkg::BDV_SPEC_BOOT, 1'b1, 1'b0);
    bus_cyc(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 16'h1004, 1'b1, 1'b0);
    mode_case(1'b0, 1'b1, bdv_pkg::BDV_SPEC_TEST, 1'b1, 1'b1);
    bus_cyc(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0040, 1'b1, 1'b0);
    bus_cyc(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 16'hB61E, 1'b1, 1'b0);
    bus_cyc(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 16'h1007, 1'b0, 1'b1);
    bus_cyc(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 16'hE000, 1'b0, 1'b1);
    cyc = 1'b0;
    @(negedge clk);
    chk(m_oe, 1'b0);
    chk(mode, bdv_pkg::BDV_SPEC_TEST);
    wr_echo(1'b0, 1'b0, 1'b0);
    wr_echo(1'b1, 1'b0, 1'b0);
    bus_cyc(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0041, 1'b0, 1'b0);
    cyc = 1'b0;
    do_reset(1'b1, 1'b1);
    wr_echo(1'b1, 1'b0, 1'b1);
    bus_cyc(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 16'hB600, 1'b0, 1'b0);
    chk(d_oe_n, 1'b0);
    bus_cyc(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0050, 1'b0, 1'b0);
    chk(d_oe_n, 1'b1);
    chk(d_out_n, 8'hF5);
    cyc = 1'b0;
    wr_echo(1'b0, 1'b0, 1'b0);
    wr_echo(1'b1, 1'b0, 1'b0);
    hirq = 1'b1;
    @(negedge clk);
    chk(irq, 1'b1);
    hirq = 1'b0;
    xirq = 1'b1;
    @(negedge clk);
    chk(irq, 1'b1);
    xirq = 1'b0;
    @(negedge clk);
    chk(irq, 1'b0);
    finish_test();
  end
endmodule
